/* File: common/sfd_pkg.sv */
// Purpose: constants shared by the supply fault detector logic
// Assumes: 50 MHz pclk, APB with 32-bit data
// Notes: channel 0 high-volt, 1-3 positive, 4-7 dual-role
package sfd_pkg;
  localparam int NCH = 8;
  localparam int NDED = 4;
  // Register byte offsets
  localparam logic [7:0] OFS_CFG0 = 8'h00;
  localparam logic [7:0] OFS_FILT = 8'h20;
  localparam logic [7:0] OFS_STATE = 8'h24;
  localparam logic [7:0] OFS_IRQ_STS = 8'h28;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h2C;
  // Channel config field positions
  localparam int F_LO = 0;
  localparam int F_HI = 8;
  localparam int F_HYST = 16;
  localparam int F_MODE = 21;
  localparam int F_RANGE = 23;
  localparam int F_ROLE = 25;
  localparam int CFG_W = 26;
  localparam logic [CFG_W-1:0] CFG_RST = 26'h0000000;
  localparam logic [6:0] FILT_RST = 7'h00;
  localparam logic [6:0] FILT_MAX_US = 7'h64;
  // Fault modes
  typedef enum logic [1:0] {
    SFD_OFF = 2'b00,
    SFD_UV = 2'b01,
    SFD_OV = 2'b10,
    SFD_WIN = 2'b11
  } sfd_mode_type;
  // Ranges: 0.573/0.802, 1.25/1.75, 2.5/3.5, 6.0/8.4 volts bottom/span
  localparam logic [1:0] RNG_LOWEST = 2'h0;
  localparam logic [1:0] RNG_MID = 2'h1;
  localparam logic [1:0] RNG_25 = 2'h2;
  localparam logic [1:0] RNG_60 = 2'h3;
  // Time base
  localparam int CLK_MHZ = 50;
  localparam int TICK_US = 1;
  localparam int TICK_CYC = CLK_MHZ * TICK_US;
endpackage : sfd_pkg

/* File: hdl/sfd_fault_detector.sv */
// Purpose: digital side of eight supply fault detectors with APB registers
// Assumes: comparator outputs arrive asynchronously; thresholds fed as codes
// Notes: hysteresis is applied as code offset on the active reference
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/100ps
module sfd_fault_detector
  import sfd_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Comparators and logic pins
  input wire logic [NCH-1:0] uv_cmp,
  input wire logic [NCH-1:0] ov_cmp,
  input wire logic [NDED-1:0] dual_pin,
  // Reference codes and range selects to analog
  output logic [NCH*8-1:0] uv_ref,
  output logic [NCH*8-1:0] ov_ref,
  output logic [NCH*2-1:0] range_sel,
  // To sequencing engine
  output logic [NCH-1:0] fault_out,
  output logic [NDED-1:0] logic_out,
  output logic warn_out,
  output logic irq
);

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic [CFG_W-1:0] cfg_q [NCH];
  logic [6:0] filt_q;
  logic [11:0] sts_q;
  logic [11:0] mask_q;
  logic [NCH-1:0] uv_m, uv_s, ov_m, ov_s, raw, st_q;
  logic [NDED-1:0] pin_m, pin_s, warn_q;
  logic [5:0] tick_cnt_q;
  logic tick_q;
  logic [31:0] rd_mux;
  wire setup = psel & ~penable;
  wire wr_en = psel & penable & pwrite & pready;
  wire is_cfg = paddr[7:5] == 3'h0 && paddr[1:0] == 2'h0;
  wire [2:0] cfg_idx = paddr[4:2];
  wire mapped = is_cfg || paddr == OFS_FILT || paddr == OFS_STATE || paddr == OFS_IRQ_STS
    || paddr == OFS_IRQ_MASK;
  wire [7:0] dual_role = {cfg_q[7][F_ROLE], cfg_q[6][F_ROLE], cfg_q[5][F_ROLE], cfg_q[4][F_ROLE], 4'h0};
  wire [6:0] tmo = (pwdata[6:0] > FILT_MAX_US) ? FILT_MAX_US : pwdata[6:0];
  logic [NCH-1:0] fault_d1;
  logic [NDED-1:0] warn_q_d1;
  wire [11:0] ev_new = {warn_q, fault_out} & ~{warn_q_d1, fault_d1};
  wire [3:0] warn_q_next = st_q[7:4] & dual_role[7:4];

  // Read selection, unmapped reads as zero
  always_comb
  begin
    rd_mux = 32'h00000000;
    if (is_cfg)
      rd_mux = {6'h00, cfg_q[cfg_idx]};
    else if (paddr == OFS_FILT)
      rd_mux = {25'h0000000, filt_q};
    else if (paddr == OFS_STATE)
      rd_mux = {16'h0000, logic_out, warn_q, fault_out};
    else if (paddr == OFS_IRQ_STS)
      rd_mux = {20'h00000, sts_q};
    else if (paddr == OFS_IRQ_MASK)
      rd_mux = {20'h00000, mask_q};
  end

  // One wait-free access cycle: answer prepared in setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= setup ? rd_mux : 32'h00000000;
    end
  end

  // ----------------------------------------
  // Time base: one tick per microsecond
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_cnt_q <= 6'h00;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= tick_cnt_q == 6'(TICK_CYC - 1);
      tick_cnt_q <= (tick_cnt_q == 6'(TICK_CYC - 1)) ? 6'h00 : tick_cnt_q + 6'h01;
    end
  end

  // Filter timeout register, clamped at 100 us
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      filt_q <= FILT_RST;
    else if (wr_en && paddr == OFS_FILT)
      filt_q <= tmo;
  end

  // ----------------------------------------
  // Per-channel detectors
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < NCH; i++)
    begin : g_ch
      logic [6:0] cnt_q;
      wire [7:0] lo = cfg_q[i][F_LO +: 8];
      wire [7:0] hi = cfg_q[i][F_HI +: 8];
      wire [4:0] hyst = cfg_q[i][F_HYST +: 5];
      wire [1:0] mode = cfg_q[i][F_MODE +: 2];
      wire [1:0] rq = pwdata[F_RANGE +: 2];
      // Hysteresis in volts is span*N/255, one code step per N
      wire [8:0] lo_up = {1'b0, lo} + {4'h0, hyst};
      wire [8:0] hi_dn = {1'b0, hi} - {4'h0, hyst};
      wire [1:0] rng = (i == 0) ? ((rq < RNG_25) ? RNG_25 : rq) : (i < NDED) ? ((rq == RNG_60) ? RNG_25 : rq)
        : RNG_LOWEST;
      wire uv_on = mode == SFD_UV || mode == SFD_WIN;
      wire ov_on = mode == SFD_OV || mode == SFD_WIN;

      // Config write, range forced legal for the channel kind
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          cfg_q[i] <= CFG_RST;
        else if (wr_en && is_cfg && cfg_idx == 3'(i))
          cfg_q[i] <= {(i >= NDED) & pwdata[F_ROLE], rng, pwdata[F_RANGE-1:0]};
      end

      // Two-flop synchronisers
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          {uv_m[i], uv_s[i], ov_m[i], ov_s[i]} <= 4'h0;
        end
        else
        begin
          uv_m[i] <= uv_cmp[i];
          uv_s[i] <= uv_m[i];
          ov_m[i] <= ov_cmp[i];
          ov_s[i] <= ov_m[i];
        end
      end

      // Window fault as OR of both comparators
      assign raw[i] = (uv_on & uv_s[i]) | (ov_on & ov_s[i]);

      // Reference codes widen the band only while the synchronised comparator trips
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          uv_ref[i*8 +: 8] <= 8'h00;
          ov_ref[i*8 +: 8] <= 8'h00;
          range_sel[i*2 +: 2] <= (i == 0) ? RNG_25 : RNG_LOWEST;
        end
        else
        begin
          uv_ref[i*8 +: 8] <= (uv_on & uv_s[i]) ? (lo_up[8] ? 8'hFF : lo_up[7:0]) : lo;
          ov_ref[i*8 +: 8] <= (ov_on & ov_s[i]) ? (hi_dn[8] ? 8'h00 : hi_dn[7:0]) : hi;
          // High-volt config reads range 0 until written, so the pins are held legal
          range_sel[i*2 +: 2] <= (i == 0 && !cfg_q[i][F_RANGE+1]) ? RNG_25 : cfg_q[i][F_RANGE +: 2];
        end
      end

      // Glitch filter: state moves on the tick after timeout ticks of disagreement, or on the next clock if timeout is 0
      // The first tick may come at once, so one extra tick keeps short pulses out
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          st_q[i] <= 1'b0;
          cnt_q <= 7'h00;
        end
        else if (raw[i] == st_q[i])
          cnt_q <= 7'h00;
        else if (filt_q == 7'h00 || (tick_q && cnt_q >= filt_q))
        begin
          st_q[i] <= raw[i];
          cnt_q <= 7'h00;
        end
        else if (tick_q)
          cnt_q <= cnt_q + 7'h01;
      end

      // A dual channel in logic role reports no fault
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          fault_out[i] <= 1'b0;
        else
          fault_out[i] <= st_q[i] & ~dual_role[i];
      end
    end
  endgenerate

  // ----------------------------------------
  // Logic inputs and warnings
  // ----------------------------------------
  // Dual channel 4+d in logic role drives logic_out bit d from pin d and warning bit d from its own state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_m <= 4'h0;
      pin_s <= 4'h0;
      logic_out <= 4'h0;
      warn_q <= 4'h0;
      warn_out <= 1'b0;
    end
    else
    begin
      pin_m <= dual_pin;
      pin_s <= pin_m;
      logic_out <= pin_s & dual_role[7:4];
      warn_q <= st_q[7:4] & dual_role[7:4];
      warn_out <= |(st_q[7:4] & dual_role[7:4]);
    end
  end

  // ----------------------------------------
  // Interrupts: sticky, W1C, set wins
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fault_d1 <= 8'h00;
      warn_q_d1 <= 4'h0;
      sts_q <= 12'h000;
      mask_q <= 12'h000;
      irq <= 1'b0;
    end
    else
    begin
      fault_d1 <= fault_out;
      warn_q_d1 <= warn_q;
      sts_q <= (sts_q & ~((wr_en && paddr == OFS_IRQ_STS) ? pwdata[11:0] : 12'h000)) | ev_new;
      if (wr_en && paddr == OFS_IRQ_MASK)
        mask_q <= pwdata[11:0];
      irq <= |(sts_q & mask_q);
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_role_exclusive: assert property (((fault_out[7:4] | logic_out) & ~fault_out[7:4]) == logic_out)
    else $error("dual fault and logic both active");
  a_dual_range: assert property (range_sel[15:8] == 8'h00)
    else $error("dual channel range not lowest");
  a_hv_range: assert property (range_sel[1] == 1'b1)
    else $error("high-volt channel range too low");
  a_uv_hyst: assert property ((uv_s[1] && cfg_q[1][F_MODE] && !g_ch[1].lo_up[8]) |=>
    uv_ref[15:8] == $past(g_ch[1].lo_up[7:0]))
    else $error("uv reference lacks hysteresis");
  a_ov_hyst: assert property ((ov_s[2] && cfg_q[2][F_MODE+1] && !g_ch[2].hi_dn[8]) |=>
    ov_ref[23:16] == $past(g_ch[2].hi_dn[7:0]))
    else $error("ov reference lacks hysteresis");
  a_filter_moves: assert property ($changed(st_q[0]) |-> $past(raw[0]) != $past(st_q[0]))
    else $error("filter state moved without cause");
  a_filter_zero: assert property ((filt_q == 7'h00 && raw[3] != st_q[3]) |=> st_q[3] == $past(raw[3]))
    else $error("zero timeout did not pass");
  a_tick_gap: assert property (tick_q |=> !tick_q [*8])
    else $error("time base ticks too often");
  a_window_or: assert property ((cfg_q[4][F_MODE +: 2] == SFD_WIN && ov_s[4]) |-> raw[4])
    else $error("window misses overvoltage");
  a_warn_or: assert property (warn_out == $past(|warn_q_next))
    else $error("warning OR wrong");
  a_irq_level: assert property (irq == $past(|(sts_q & mask_q)))
    else $error("interrupt level wrong");
  a_set_wins: assert property (ev_new[0] |=> sts_q[0])
    else $error("event lost on clear");

  c_uv_fault: cover property (raw[1] ##1 raw[1] [*8] ##[1:300] fault_out[1]);
  c_glitch: cover property (filt_q > 7'h01 && $rose(raw[1]) ##[1:160] $fell(raw[1]));
  c_warn: cover property ($rose(warn_out));
  c_irq: cover property ($rose(irq));
endmodule : sfd_fault_detector

/* File: bench/sfd_rail_model.sv */
// Purpose: comparator model standing between the rails and the detector
// Assumes: rail levels given as codes of the selected range
// Notes: ideal comparators; hysteresis is carried by the references
`timescale 1ns/100ps
module sfd_rail_model
  import sfd_pkg::*;
(
  // Rail codes and references
  input wire logic [NCH*8-1:0] rail,
  input wire logic [NCH*8-1:0] uv_ref,
  input wire logic [NCH*8-1:0] ov_ref,
  // Comparator results
  output logic [NCH-1:0] uv_cmp,
  output logic [NCH-1:0] ov_cmp
);
  // No offset or noise, so every glitch comes from the bench
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      uv_cmp[i] = rail[8*i+:8] < uv_ref[8*i+:8];
      ov_cmp[i] = rail[8*i+:8] > ov_ref[8*i+:8];
    end
  end
endmodule : sfd_rail_model

/* File: bench/sfd_fault_detector_bench.sv */
// Purpose: self-checking bench for the fault detector
// Assumes: APB slave answers in the first access cycle
// Notes: filter waits are bounded by tick jitter of one us
`timescale 1ns/100ps
`define CHK(s, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; $display("[ERR] %s exp %0h got %0h", s, e, g); end end
module sfd_fault_detector_bench
  import sfd_pkg::*;
  ;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, err, seen, warn_out, irq;
  logic [NCH-1:0] uv_cmp, ov_cmp, fault_out;
  logic [NDED-1:0] dual_pin = 4'h0, logic_out;
  logic [NCH*8-1:0] uv_ref, ov_ref, rail = {8{8'hFF}};
  logic [NCH*2-1:0] range_sel;
  logic [7:0] lo, rv;
  logic [4:0] hy;
  logic [1:0] rg;
  int fails = 0, tests_run = 0, seed = 32'h44fecf57, n;
  always #10 pclk = ~pclk;
  sfd_fault_detector i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .uv_cmp(uv_cmp),
    .ov_cmp(ov_cmp), .dual_pin(dual_pin), .uv_ref(uv_ref), .ov_ref(ov_ref), .range_sel(range_sel),
    .fault_out(fault_out), .logic_out(logic_out), .warn_out(warn_out), .irq(irq));
  sfd_rail_model i_rail (.rail(rail), .uv_ref(uv_ref), .ov_ref(ov_ref), .uv_cmp(uv_cmp), .ov_cmp(ov_cmp));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task complete_run;
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run
  // One transfer, then an idle edge so psel is never driven twice at once
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20)
    begin
      @(posedge pclk);
      k++;
    end
    if (pready !== 1'b1)
    begin
      fails++;
      complete_run;
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task wt(input int ch, input logic v, input int lim);
    n = 0;
    while (fault_out[ch] !== v && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    if (fault_out[ch] !== v)
    begin
      fails++;
      complete_run;
    end
  endtask : wt
  task hold(input int ch, input int cyc);
    seen = 1'b0;
    repeat (cyc)
    begin
      @(posedge pclk);
      seen = seen | fault_out[ch];
    end
  endtask : hold
  function automatic logic [31:0] cfg(logic [7:0] l, h, logic [4:0] y, logic [1:0] m, g, logic role);
    return {6'h00, role, g, m, y, h, l};
  endfunction : cfg
  // Reference while an undervoltage is active saturates at full scale
  function automatic logic [7:0] up_ref(logic [7:0] l, logic [4:0] y);
    return (l + y > 255) ? 8'hFF : l + y;
  endfunction : up_ref
  function automatic logic [1:0] coerce(int ch, logic [1:0] g);
    return (ch == 0) ? ((g < 2) ? 2'h2 : g) : (ch < 4) ? ((g == 3) ? 2'h2 : g) : 2'h0;
  endfunction : coerce
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values and an unmapped place
    apb(0, OFS_CFG0, 0);
    `CHK("cfg0 reset", 32'h0, r)
    apb(0, OFS_FILT, 0);
    `CHK("filt reset", 32'h0, r)
    apb(0, 8'h30, 0);
    `CHK("unmapped err", 1'b1, err)
    // Random range per channel kind
    for (int c = 0; c < NCH; c++)
    begin
      rg = 2'($random(seed));
      apb(1, 8'(4 * c), cfg(8'h00, 8'hFF, 5'h00, SFD_OFF, rg, 0));
      apb(0, 8'(4 * c), 0);
      `CHK("range field", coerce(c, rg), r[24:23])
      `CHK("range pins", coerce(c, rg), range_sel[2*c+:2])
    end
    // Undervoltage with hysteresis
    apb(1, 8'h04, cfg(8'h80, 8'hFF, 5'h10, SFD_UV, RNG_25, 0));
    rail[15:8] <= 8'h7F;
    wt(1, 1, 20);
    `CHK("uv ref", 8'h90, uv_ref[15:8])
    rail[15:8] <= 8'h88;
    repeat (20) @(posedge pclk);
    `CHK("uv held", 1'b1, fault_out[1])
    rail[15:8] <= 8'h91;
    wt(1, 0, 20);
    // Overvoltage, then window on the same rail
    rail[23:16] <= 8'h30;
    apb(1, 8'h08, cfg(8'h20, 8'h40, 5'h05, SFD_OV, RNG_MID, 0));
    rail[23:16] <= 8'h41;
    wt(2, 1, 20);
    `CHK("ov ref", 8'h3B, ov_ref[23:16])
    rail[23:16] <= 8'h3C;
    repeat (20) @(posedge pclk);
    `CHK("ov held", 1'b1, fault_out[2])
    rail[23:16] <= 8'h3A;
    wt(2, 0, 20);
    rail[23:16] <= 8'h1F;
    hold(2, 20);
    `CHK("ov ignores low", 1'b0, seen)
    apb(1, 8'h08, cfg(8'h20, 8'h40, 5'h05, SFD_WIN, RNG_MID, 0));
    hold(2, 10);
    `CHK("window low", 1'b1, fault_out[2])
    rail[23:16] <= 8'h30;
    wt(2, 0, 20);
    // Random thresholds, saturating corner first
    for (int i = 0; i < 6; i++)
    begin
      lo = (i == 0) ? 8'hF8 : 8'($random(seed));
      hy = (i == 0) ? 5'h1F : 5'($random(seed));
      rv = (i == 0) ? 8'h00 : 8'($random(seed));
      apb(1, 8'h0C, cfg(lo, 8'hFF, hy, SFD_UV, RNG_25, 0));
      apb(0, 8'h0C, 0);
      `CHK("cfg3 back", cfg(lo, 8'hFF, hy, SFD_UV, RNG_25, 0), r)
      rail[31:24] <= rv;
      repeat (10) @(posedge pclk);
      `CHK("rand fault", rv < lo, fault_out[3])
      `CHK("rand ref", (rv < lo) ? up_ref(lo, hy) : lo, uv_ref[31:24])
      rail[31:24] <= 8'hFF;
      wt(3, 0, 20);
    end
    // Filter clamp, glitches and delay
    apb(1, OFS_FILT, 32'h7F);
    apb(0, OFS_FILT, 0);
    `CHK("filt clamp", 32'(FILT_MAX_US), r)
    apb(1, OFS_FILT, 32'h4);
    rail[15:8] <= 8'h7F;
    repeat (140) @(posedge pclk);
    rail[15:8] <= 8'hA0;
    repeat (20) @(posedge pclk);
    rail[15:8] <= 8'h7F;
    repeat (140) @(posedge pclk);
    rail[15:8] <= 8'hA0;
    hold(1, 300);
    `CHK("glitches", 1'b0, seen)
    rail[15:8] <= 8'h7F;
    wt(1, 1, 400);
    `CHK("delay set", 1'b1, n >= 200 && n <= 260)
    rail[15:8] <= 8'hA0;
    wt(1, 0, 400);
    `CHK("delay clear", 1'b1, n >= 200 && n <= 260)
    // Interrupt set, masked, cleared
    apb(1, OFS_FILT, 0);
    apb(1, OFS_IRQ_STS, 32'hFFF);
    apb(1, OFS_IRQ_MASK, 32'h2);
    `CHK("irq idle", 1'b0, irq)
    rail[15:8] <= 8'h7F;
    wt(1, 1, 20);
    repeat (3) @(posedge pclk);
    `CHK("irq set", 1'b1, irq)
    apb(0, OFS_IRQ_STS, 0);
    `CHK("sts", 32'h2, r)
    apb(1, OFS_IRQ_STS, 32'h2);
    repeat (2) @(posedge pclk);
    `CHK("irq clear", 1'b0, irq)
    // Dual-role channel in logic role
    rail[47:40] <= 8'h10;
    dual_pin <= 4'h2;
    apb(1, 8'h14, cfg(8'h80, 8'hFF, 5'h00, SFD_UV, RNG_LOWEST, 1));
    repeat (10) @(posedge pclk);
    `CHK("no analog", 1'b0, fault_out[5])
    `CHK("logic pin", 4'h2, logic_out)
    `CHK("warn", 1'b1, warn_out)
    apb(0, OFS_STATE, 0);
    `CHK("state", 16'h2202, r[15:0])
    complete_run;
  end
  // Hang guard
  initial
  begin
    #1500000;
    fails++;
    complete_run;
  end
endmodule : sfd_fault_detector_bench
